// ==== src/fcpwm_pkg.sv ====
// Purpose: Shared constants and types of the four channel pulse width unit.
// Assumes: APB slave decoding 12 address bits, one 32-bit word per register.
// Notes: Reserved bits are stored as zero and read as zero.
package fcpwm_pkg;
    localparam int NCH  = 4;
    localparam int NPRE = 11;
    localparam int NCLK = 13;

    localparam logic [11:0] OFF_GEN_MODE   = 12'h000;
    localparam logic [11:0] OFF_CH_ENABLE  = 12'h004;
    localparam logic [11:0] OFF_CH_DISABLE = 12'h008;
    localparam logic [11:0] OFF_CH_STATUS  = 12'h00C;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h010;
    localparam logic [11:0] OFF_IRQ_DISABLE = 12'h014;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h018;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h01C;

    localparam logic [2:0] CH_REGION = 3'h1;
    localparam logic [4:0] CH_MODE   = 5'h00;
    localparam logic [4:0] CH_DUTY   = 5'h04;
    localparam logic [4:0] CH_PERIOD = 5'h08;
    localparam logic [4:0] CH_COUNT  = 5'h0C;
    localparam logic [4:0] CH_UPDATE = 5'h10;

    localparam logic [3:0] PRE_LAST = 4'hA;
    localparam logic [3:0] SEL_LAST = 4'hC;
    localparam logic       TGT_DUTY = 1'b0;

    typedef struct packed {
        logic [3:0] rsv_hi;
        logic [3:0] divider_b_source_sel;
        logic [7:0] divider_b_factor;
        logic [3:0] rsv_lo;
        logic [3:0] divider_a_source_sel;
        logic [7:0] divider_a_factor;
    } fcpwm_gen_mode_t;

    typedef struct packed {
        logic [20:0] rsv_hi;
        logic        update_target_sel;
        logic        start_polarity;
        logic        alignment_sel;
        logic [3:0]  rsv_lo;
        logic [3:0]  channel_clock_sel;
    } fcpwm_ch_mode_t;

    localparam logic [31:0]     GEN_MODE_WMASK = 32'h0FFF0FFF;
    localparam logic [31:0]     CH_MODE_WMASK  = 32'h0000070F;
    localparam fcpwm_gen_mode_t GEN_MODE_RST   = '0;
    localparam fcpwm_ch_mode_t  CH_MODE_RST    = '0;
    localparam logic [15:0]     VAL_RST        = 16'h0000;

    typedef enum logic {CNT_UP = 1'b0, CNT_DOWN = 1'b1} fcpwm_dir_t;
endpackage

// ==== src/fcpwm_top.sv ====
// Purpose: Four channel pulse width unit with shared clock generator, APB slave.
// Assumes: All logic runs on pclk, which stands for the master clock input.
// Notes: Zero wait state APB, answer registered in the setup cycle.

module fcpwm_top
    import fcpwm_pkg::*;
(
    input  wire logic           pclk,
    input  wire logic           presetn,
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    output logic      [NCH-1:0] waveform_out,
    output logic                irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    fcpwm_gen_mode_t generator_mode_r;
    logic [NCH-1:0]  channel_enable_r;
    logic [NCH-1:0]  irq_mask_r;
    logic [NCH-1:0]  irq_status_r;
    logic            irq_r;
    logic            pready_r;
    logic            pslverr_r;
    logic [31:0]     prdata_r;
    logic [9:0]      pre_r;
    logic [NPRE-1:0] tick_pre;
    logic [1:0]      div_tick;
    logic [7:0]      div_fac [2];
    logic [3:0]      div_src [2];
    logic [NCLK-1:0] ticks;
    logic [NCH-1:0]  eop;
    logic [NCH-1:0]  wave;
    fcpwm_ch_mode_t  ch_mode [NCH];
    logic [15:0]     ch_duty [NCH];
    logic [15:0]     ch_period [NCH];
    logic [15:0]     ch_count [NCH];
    logic [31:0]     rd_data;
    logic            rd_err;

    wire             setup    = psel & ~penable;
    wire             done     = psel & penable & pready_r;
    wire             wr       = done & pwrite;
    wire             in_ch    = (paddr[11:9] == CH_REGION) && (paddr[8:7] == 2'b00);
    wire [1:0]       ch_sel   = paddr[6:5];
    wire [4:0]       ch_off   = paddr[4:0];
    wire             hit_wo   = (paddr == OFF_CH_ENABLE) || (paddr == OFF_CH_DISABLE) ||
                                (paddr == OFF_IRQ_ENABLE) || (paddr == OFF_IRQ_DISABLE);
    wire [NCH-1:0]   ena_bits = (wr && paddr == OFF_CH_ENABLE) ? pwdata[NCH-1:0] : '0;
    wire [NCH-1:0]   dis_bits = (wr && paddr == OFF_CH_DISABLE) ? pwdata[NCH-1:0] : '0;
    wire [NCH-1:0]   ier_bits = (wr && paddr == OFF_IRQ_ENABLE) ? pwdata[NCH-1:0] : '0;
    wire [NCH-1:0]   idr_bits = (wr && paddr == OFF_IRQ_DISABLE) ? pwdata[NCH-1:0] : '0;
    wire             isr_rd   = done && !pwrite && (paddr == OFF_IRQ_STATUS);
    wire [NCH-1:0]   isr_clr  = isr_rd ? prdata_r[NCH-1:0] : '0;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign irq     = irq_r;

    // Read data is chosen in the setup cycle; misaligned or unmapped words error.
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (paddr == OFF_GEN_MODE) begin
            rd_data = generator_mode_r;
        end else if (hit_wo) begin
            rd_data = '0;
        end else if (paddr == OFF_CH_STATUS) begin
            rd_data = {28'h0000000, channel_enable_r};
        end else if (paddr == OFF_IRQ_MASK) begin
            rd_data = {28'h0000000, irq_mask_r};
        end else if (paddr == OFF_IRQ_STATUS) begin
            rd_data = {28'h0000000, irq_status_r};
        end else if (in_ch && ch_off == CH_MODE) begin
            rd_data = ch_mode[ch_sel];
        end else if (in_ch && ch_off == CH_DUTY) begin
            rd_data = {16'h0000, ch_duty[ch_sel]};
        end else if (in_ch && ch_off == CH_PERIOD) begin
            rd_data = {16'h0000, ch_period[ch_sel]};
        end else if (in_ch && ch_off == CH_COUNT) begin
            rd_data = {16'h0000, ch_count[ch_sel]};
        end else if (in_ch && ch_off == CH_UPDATE) begin
            rd_data = '0;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & rd_err;
            if (setup) begin
                prdata_r <= rd_data;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            generator_mode_r <= GEN_MODE_RST;
            channel_enable_r <= '0;
            irq_mask_r       <= '0;
            irq_status_r     <= '0;
            irq_r            <= 1'b0;
        end else begin
            if (wr && paddr == OFF_GEN_MODE) begin
                generator_mode_r <= fcpwm_gen_mode_t'(pwdata & GEN_MODE_WMASK);
            end
            channel_enable_r <= (channel_enable_r | ena_bits) & ~dis_bits;
            irq_mask_r       <= (irq_mask_r | ier_bits) & ~idr_bits;
            irq_status_r     <= (irq_status_r & ~isr_clr) | eop;
            irq_r            <= |(irq_status_r & irq_mask_r);
        end
    end

    // The prescaler free runs modulo 1024; it restarts at reset, so every divided tick waits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= 10'h000;
        end else begin
            pre_r <= pre_r + 10'h001;
        end
    end

    for (genvar k = 0; k < NPRE; k++) begin : g_pre
        if (k == 0) begin : g_full
            assign tick_pre[k] = 1'b1;
        end else begin : g_part
            assign tick_pre[k] = &pre_r[k-1:0];
        end
    end

    assign div_fac[0] = generator_mode_r.divider_a_factor;
    assign div_fac[1] = generator_mode_r.divider_b_factor;
    assign div_src[0] = generator_mode_r.divider_a_source_sel;
    assign div_src[1] = generator_mode_r.divider_b_source_sel;

    for (genvar d = 0; d < 2; d++) begin : g_div
        logic [7:0] dcnt_r;
        wire        src_tick = (div_src[d] <= PRE_LAST) ? tick_pre[div_src[d]] : 1'b0;
        wire        wrap     = dcnt_r >= (div_fac[d] - 8'h01);
        assign div_tick[d] = (div_fac[d] != 8'h00) & src_tick & wrap;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                dcnt_r <= 8'h00;
            end else if (div_fac[d] == 8'h00) begin
                dcnt_r <= 8'h00;
            end else if (src_tick) begin
                dcnt_r <= wrap ? 8'h00 : dcnt_r + 8'h01;
            end
        end
    end

    assign ticks = {div_tick, tick_pre};

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        fcpwm_ch_mode_t mode_r;
        fcpwm_dir_t     dir_r;
        fcpwm_dir_t     dir_nxt;
        logic [15:0]    cnt_r;
        logic [15:0]    cnt_nxt;
        logic [15:0]    prd_r;
        logic [15:0]    dty_r;
        logic [15:0]    upd_r;
        logic           pend_r;
        logic           pol_r;
        logic           alg_r;
        logic           wave_r;
        logic           end_c;
        wire            en       = channel_enable_r[i];
        wire            wr_ch    = wr && in_ch && (ch_sel == 2'(i));
        wire            start    = ena_bits[i] & ~en;
        wire [3:0]      csel     = mode_r.channel_clock_sel;
        wire            ch_tick  = (csel <= SEL_LAST) ? ticks[csel] : 1'b0;
        wire            at_top   = (cnt_r + 16'h0001) >= prd_r;
        wire            low_side = (dty_r == prd_r) || (cnt_r < dty_r);

        always_comb begin
            cnt_nxt = cnt_r;
            dir_nxt = dir_r;
            end_c   = 1'b0;
            if (start) begin
                cnt_nxt = VAL_RST;
                dir_nxt = CNT_UP;
            end else if (en && ch_tick) begin
                if (!alg_r) begin
                    if (at_top) begin
                        cnt_nxt = VAL_RST;
                        end_c   = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end else if (dir_r == CNT_UP) begin
                    if (at_top) begin
                        cnt_nxt = prd_r;
                        dir_nxt = CNT_DOWN;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end else if (cnt_r <= 16'h0001) begin
                    cnt_nxt = VAL_RST;
                    dir_nxt = CNT_UP;
                    end_c   = 1'b1;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mode_r <= CH_MODE_RST;
                dir_r  <= CNT_UP;
                cnt_r  <= VAL_RST;
                pol_r  <= 1'b0;
                alg_r  <= 1'b0;
                wave_r <= 1'b0;
            end else begin
                if (wr_ch && ch_off == CH_MODE) begin
                    mode_r <= fcpwm_ch_mode_t'(pwdata & CH_MODE_WMASK);
                end
                dir_r <= dir_nxt;
                cnt_r <= cnt_nxt;
                if (!en) begin
                    pol_r <= mode_r.start_polarity;
                    alg_r <= mode_r.alignment_sel;
                end
                // Disabled outputs follow polarity at once; enabled ones compare.
                if (en) begin
                    wave_r <= low_side ? pol_r : ~pol_r;
                end else begin
                    wave_r <= mode_r.start_polarity;
                end
            end
        end

        // Direct writes are ignored while running so a live period never tears.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prd_r  <= VAL_RST;
                dty_r  <= VAL_RST;
                upd_r  <= VAL_RST;
                pend_r <= 1'b0;
            end else begin
                if (wr_ch && ch_off == CH_PERIOD && !en) begin
                    prd_r <= pwdata[15:0];
                end else if (end_c && pend_r && mode_r.update_target_sel != TGT_DUTY) begin
                    prd_r <= upd_r;
                end
                if (wr_ch && ch_off == CH_DUTY && !en) begin
                    dty_r <= pwdata[15:0];
                end else if (end_c && pend_r && mode_r.update_target_sel == TGT_DUTY) begin
                    dty_r <= upd_r;
                end
                if (wr_ch && ch_off == CH_UPDATE) begin
                    upd_r <= pwdata[15:0];
                end
                pend_r <= (wr_ch && ch_off == CH_UPDATE) | (pend_r & ~end_c);
            end
        end

        assign eop[i]       = end_c;
        assign wave[i]      = wave_r;
        assign ch_mode[i]   = mode_r;
        assign ch_duty[i]   = dty_r;
        assign ch_period[i] = prd_r;
        assign ch_count[i]  = cnt_r;
    end

    assign waveform_out = wave;

    property p_pre_half;
        tick_pre[1] |=> !tick_pre[1] ##1 tick_pre[1];
    endproperty
    a_pre_half: assert property (p_pre_half) else $error("half rate tick not alternating");

    property p_div_stop;
        (div_fac[0] == 8'h00) [*2] |-> !div_tick[0];
    endproperty
    a_div_stop: assert property (p_div_stop) else $error("divider A ticks with factor zero");

    property p_div_three;
        (div_tick[0] && div_fac[0] == 8'h03 && div_src[0] == 4'h0 && $stable(div_fac[0]))
            |=> !div_tick[0] ##1 !div_tick[0] ##1 div_tick[0];
    endproperty
    a_div_three: assert property (p_div_three) else $error("divider A by three wrong");

    property p_hold_dis;
        (!channel_enable_r[0] && !ena_bits[0]) |=> $stable(g_ch[0].cnt_r);
    endproperty
    a_hold_dis: assert property (p_hold_dis) else $error("disabled counter moved");

    property p_sync_start;
        (ena_bits[0] && ena_bits[1] && channel_enable_r[1:0] == 2'b00)
            |=> g_ch[0].cnt_r == 16'h0000 && g_ch[1].cnt_r == 16'h0000;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("synchronized start missed");

    property p_left_wrap;
        (channel_enable_r[0] && !g_ch[0].alg_r && g_ch[0].ch_tick && g_ch[0].at_top && !ena_bits[0])
            |=> g_ch[0].cnt_r == 16'h0000 && irq_status_r[0];
    endproperty
    a_left_wrap: assert property (p_left_wrap) else $error("left aligned wrap wrong");

    property p_center_turn;
        (channel_enable_r[0] && g_ch[0].alg_r && g_ch[0].dir_r == CNT_UP && g_ch[0].ch_tick
            && g_ch[0].at_top && !ena_bits[0]) |=> g_ch[0].dir_r == CNT_DOWN && !irq_status_r[0] | $past(irq_status_r[0]);
    endproperty
    a_center_turn: assert property (p_center_turn) else $error("center turn wrong");

    property p_isr_clear;
        (isr_rd && prdata_r[0] && !eop[0]) |=> !irq_status_r[0];
    endproperty
    a_isr_clear: assert property (p_isr_clear) else $error("status read did not clear");

    property p_eop_set;
        eop[0] |=> irq_status_r[0] ##1 (irq_r || !irq_mask_r[0]);
    endproperty
    a_eop_set: assert property (p_eop_set) else $error("period end not flagged");

    property p_irq_mask;
        ier_bits[1] && !idr_bits[1] |=> irq_mask_r[1];
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("mask not set");

    property p_pol_dis;
        !channel_enable_r[0] |=> waveform_out[0] == $past(g_ch[0].mode_r.start_polarity);
    endproperty
    a_pol_dis: assert property (p_pol_dis) else $error("disabled output not polarity");

    property p_fix_low;
        (channel_enable_r[0] && !g_ch[0].pol_r && g_ch[0].dty_r == g_ch[0].prd_r) |=> !waveform_out[0];
    endproperty
    a_fix_low: assert property (p_fix_low) else $error("output not fixed low");

    property p_update;
        (eop[0] && g_ch[0].pend_r && g_ch[0].mode_r.update_target_sel == TGT_DUTY
            && !(wr && in_ch && ch_sel == 2'b00 && ch_off == CH_DUTY))
            |=> g_ch[0].dty_r == $past(g_ch[0].upd_r);
    endproperty
    a_update: assert property (p_update) else $error("duty update not loaded");
endmodule

// ==== tb/fcpwm_load.sv ====
// Purpose: Load circuit on the waveform pins that counts high cycles per channel.
// Assumes: One sample per rising pclk edge.
// Notes: clr zeroes every count at the next edge.
module fcpwm_load
    import fcpwm_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 clr,
    input  wire logic [NCH-1:0]       waveform_out,
    output logic      [NCH-1:0][15:0] on_cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge pclk) begin
        for (int i = 0; i < NCH; i++) begin
            on_cnt[i] <= clr ? 16'h0 : on_cnt[i] + 16'(waveform_out[i]);
        end
    end
endmodule

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench of the four channel pulse width unit.
// Assumes: Zero wait APB slave, master clock is pclk.
// Notes: Waveforms are judged by high-cycle counts over whole periods and by per-cycle samples of the pins.
module tb_top
    import fcpwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clr, e;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata, q, gm;
    logic [NCH-1:0]       waveform_out;
    logic [NCH-1:0][15:0] on_cnt;
    logic [7:0]           lfsr_r;
    logic [11:0]          rst_a [4];
    int                   errors, comparisons, cyc, ch, sel, t, ctr, pol, p, d, per, diff;

    fcpwm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .waveform_out(waveform_out), .irq(irq));
    fcpwm_load load_u (.pclk(pclk), .clr(clr), .waveform_out(waveform_out), .on_cnt(on_cnt));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic close_out;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors++;
            close_out;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction

    function automatic logic [11:0] ca(input int c, input logic [4:0] off);
        return 12'h200 + 12'(c * 32) + {7'h0, off};
    endfunction

    // High cycles in two periods; a center period holds the start level for 2d-1 ticks.
    function automatic int exp_on(input int ep, input int ed, input int epol, input int ectr, input int et);
        int eper;
        int lvl;
        eper = ectr ? 2 * ep : ep;
        lvl = (ed == ep) ? eper : (ectr && ed > 0) ? 2 * ed - 1 : ed;
        return 2 * et * (epol ? lvl : eper - lvl);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Called right after an edge; holds the request until pready is sampled high.
    // Only the cycle ceiling ends a wait that never sees pready.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic cfg(input int c, input int s, input int ce, input int po, input int tg, input int pp, input int dd);
        apb(1'b1, OFF_CH_DISABLE, 32'(1 << c));
        apb(1'b1, ca(c, CH_MODE), {21'h0, 1'(tg), 1'(po), 1'(ce), 4'h0, 4'(s)});
        apb(1'b1, ca(c, CH_DUTY), 32'(dd));
        apb(1'b1, ca(c, CH_PERIOD), 32'(pp));
    endtask

    task automatic meas(input int c, input int win, input int exp);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (win + 1) @(posedge pclk);
        chk(32'(on_cnt[c]), 32'(exp));
    endtask

    initial begin
        {presetn, psel, penable, pwrite, clr} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        lfsr_r = 8'h4A;
        {errors, comparisons, cyc, diff} = '0;
        rst_a = '{OFF_GEN_MODE, OFF_CH_STATUS, OFF_IRQ_MASK, OFF_IRQ_STATUS};
        tick(4);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(waveform_out), 32'h0);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, i < 4 ? rst_a[i] : ca(i - 4, CH_MODE), 32'h0);
            chk(q, 32'h0);
        end
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, e}, 32'h1);
        cfg(0, 11, 0, 0, 0, 4, 2);
        apb(1'b1, OFF_CH_ENABLE, 32'h1);
        tick(20);
        apb(1'b0, ca(0, CH_COUNT), 32'h0);
        chk(q, 32'h0);
        gm = {rnd(), rnd(), 16'h0003};
        apb(1'b1, OFF_GEN_MODE, gm);
        apb(1'b0, OFF_GEN_MODE, 32'h0);
        chk(q, gm & GEN_MODE_WMASK);
        // The first two rounds are corner cases on channel 0: center with zero duty, low start with full duty.
        for (int k = 0; k < 12; k++) begin
            ch = (k < 2) ? 0 : rnd() % 4;
            sel = rnd() % 4;
            if (sel == 3) sel = 11;
            t = (sel == 11) ? 3 : 1 << sel;
            ctr = (k == 0) ? 1 : rnd() % 2;
            pol = (k == 1) ? 0 : rnd() % 2;
            p = 4 + rnd() % 12;
            d = (k == 0) ? 0 : (k == 1) ? p : rnd() % (p + 1);
            cfg(ch, sel, ctr, pol, 0, p, d);
            apb(1'b1, OFF_CH_ENABLE, 32'(1 << ch));
            per = (ctr ? 2 : 1) * p * t;
            tick(per + 4);
            meas(ch, 2 * per, exp_on(p, d, pol, ctr, t));
        end
        apb(1'b1, OFF_CH_DISABLE, 32'hF);
        apb(1'b1, OFF_CH_ENABLE, 32'h1);
        apb(1'b1, OFF_CH_ENABLE, 32'h0);
        apb(1'b1, OFF_CH_DISABLE, 32'h2);
        apb(1'b0, OFF_CH_STATUS, 32'h0);
        chk(q, 32'h1);
        cfg(0, 0, 0, 0, 0, 6, 2);
        cfg(1, 0, 0, 0, 0, 6, 2);
        apb(1'b1, OFF_CH_ENABLE, 32'h3);
        repeat (40) begin
            @(posedge pclk);
            if (waveform_out[0] !== waveform_out[1]) diff++;
        end
        chk(32'(diff), 32'h0);
        cfg(3, 0, 0, 1, 0, 6, 2);
        tick(3);
        chk(32'(waveform_out[3]), 32'h1);
        apb(1'b1, OFF_CH_ENABLE, 32'h8);
        apb(1'b1, ca(3, CH_MODE), 32'h0);
        tick(8);
        meas(3, 12, exp_on(6, 2, 1, 0, 1));
        cfg(0, 0, 0, 0, 0, 8, 2);
        apb(1'b1, OFF_CH_ENABLE, 32'h1);
        apb(1'b1, ca(0, CH_UPDATE), 32'h6);
        tick(20);
        meas(0, 16, exp_on(8, 6, 0, 0, 1));
        apb(1'b1, ca(0, CH_DUTY), 32'h1);
        apb(1'b0, ca(0, CH_DUTY), 32'h0);
        chk(q, 32'h6);
        cfg(0, 10, 0, 0, 1, 8, 2);
        apb(1'b1, OFF_CH_ENABLE, 32'h1);
        apb(1'b1, ca(0, CH_UPDATE), 32'h9);
        apb(1'b0, ca(0, CH_PERIOD), 32'h0);
        chk(q, 32'h8);
        tick(8200);
        apb(1'b0, ca(0, CH_PERIOD), 32'h0);
        chk(q, 32'h9);
        apb(1'b1, OFF_CH_DISABLE, 32'hF);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        cfg(1, 0, 0, 0, 0, 100, 50);
        apb(1'b1, OFF_IRQ_ENABLE, 32'h2);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk(q, 32'h2);
        apb(1'b1, OFF_CH_ENABLE, 32'h2);
        tick(110);
        chk(32'(irq), 32'h1);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h2);
        apb(1'b0, OFF_IRQ_STATUS, 32'h0);
        chk(q, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, OFF_IRQ_DISABLE, 32'h2);
        apb(1'b0, OFF_IRQ_MASK, 32'h0);
        chk(q, 32'h0);
        tick(110);
        chk(32'(irq), 32'h0);
        close_out;
    end
endmodule
